/* src/tad_cfg.svh */
// Register map, field positions, reset values and timing constants of the trigger engine
`ifndef TAD_CFG_SVH
`define TAD_CFG_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define TAD_IDX_CMD        16'h0064
`define TAD_IDX_OUTSEL     16'h9CA4
`define TAD_IDX_ORMASK     16'h9DDA
`define TAD_IDX_MAXDLY     16'h9F60
`define TAD_IDX_DELAY      16'h9F6A
`define TAD_IDX_CTRL       16'hA000
`define TAD_IDX_PRETRIG    16'hA001
`define TAD_IDX_POSTTRIG   16'hA002
`define TAD_IDX_STATUS     16'hA003

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define TAD_CMD_START      2
`define TAD_CMD_ARM        3
`define TAD_CMD_FORCE      4
`define TAD_CMD_DISARM     5
`define TAD_CMD_STOP       6
`define TAD_OR_SOFT        0
`define TAD_OR_EXT         1
`define TAD_CTRL_SYNC      0
`define TAD_OUTSEL_DRIVE   32'h0000_0001

// ---------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------
`define TAD_RST_ORMASK     32'h0000_0001
`define TAD_RST_OUTSEL     32'h0000_0000
`define TAD_RST_DELAY      16'h0000
`define TAD_RST_PRETRIG    16'h0010
`define TAD_RST_POSTTRIG   16'h0040
`define TAD_MAX_DELAY      32'h0000_FFFF
`define TAD_HTRANS_NONSEQ  2'h2
`define TAD_HSIZE_WORD     3'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TAD_CLK_NS         50
`define TAD_SETUP_NS       200
`define TAD_SETUP_CYC      ((`TAD_SETUP_NS + `TAD_CLK_NS - 1) / `TAD_CLK_NS)

`endif

/* src/tad_pkg.sv */
// Types and shared helpers of the trigger engine
package tad_pkg;

   // ---------------------------------------------------------------
   // Engine states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_STOPPED,
      ST_SETUP,
      ST_PRETRIG,
      ST_WAIT,
      ST_DELAY,
      ST_POST
   } tad_state_t;

   typedef logic [15:0] tad_idx_t;

   // Word index from a byte address; out of range maps to all ones
   function automatic tad_idx_t tad_addr_idx(input logic [31:0] addr);
      tad_addr_idx = (addr[31:18] == 14'h0000) ? addr[17:2] : 16'hFFFF;
   endfunction : tad_addr_idx

endpackage : tad_pkg

/* src/tad_ahb_slave.sv */
// AHB-Lite slave front end: zero wait states, always OKAY
`timescale 1ns/1ps
`include "tad_cfg.svh"
module tad_ahb_slave (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             hsel_in,
   input  wire logic [31:0]      haddr_in,
   input  wire logic [1:0]       htrans_in,
   input  wire logic             hwrite_in,
   input  wire logic [2:0]       hsize_in,
   input  wire logic             hready_in,
   input  wire logic [31:0]      hwdata_in,
   output logic                  hreadyout_out,
   output logic                  hresp_out,
   output logic [31:0]           hrdata_out,
   output tad_pkg::tad_idx_t     rd_idx_out,
   input  wire logic [31:0]      rd_data_in,
   output logic                  wr_en_out,
   output tad_pkg::tad_idx_t     wr_idx_out,
   output logic [31:0]           wr_data_out
);
   import tad_pkg::*;

   logic     take;
   logic     wr_pend_q;
   tad_idx_t wr_idx_q;

   assign take        = hsel_in && hready_in && (htrans_in == `TAD_HTRANS_NONSEQ);
   assign rd_idx_out  = tad_addr_idx(haddr_in);
   assign wr_en_out   = wr_pend_q;
   assign wr_idx_out  = wr_idx_q;
   assign wr_data_out = hwdata_in;

   // Narrow writes are dropped; only whole words reach the registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 16'h0000;
      end else begin
         wr_pend_q <= take && hwrite_in && (hsize_in == `TAD_HSIZE_WORD);
         wr_idx_q  <= tad_addr_idx(haddr_in);
      end
   end

   // Read data is captured at the address phase edge
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (take && !hwrite_in) begin
         hrdata_out <= rd_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end
   end

endmodule : tad_ahb_slave

/* src/tad_trig_delay.sv */
// Programmable trigger delay stage, last element of the trigger chain
`timescale 1ns/1ps
module tad_trig_delay #(
   parameter int DLY_W = 16
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             trig_in,
   input  wire logic [DLY_W-1:0] delay_in,
   input  wire logic             bypass_in,
   output logic                  fire_out,
   output logic                  busy_out
);
   import tad_pkg::*;

   logic [DLY_W-1:0] cnt_q;
   logic [DLY_W-1:0] dly_q;
   logic [DLY_W:0]   el_q;

   // Fixed latency of one cycle; delay adds delay_in cycles on top
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_q    <= '0;
         busy_out <= 1'b0;
         fire_out <= 1'b0;
      end else begin
         fire_out <= 1'b0;
         if (trig_in && !busy_out) begin
            if (bypass_in || (delay_in == '0)) begin
               fire_out <= 1'b1;
            end else begin
               cnt_q    <= delay_in;
               busy_out <= 1'b1;
            end
         end else if (busy_out) begin
            if (cnt_q == DLY_W'(1)) begin
               busy_out <= 1'b0;
               fire_out <= 1'b1;
            end
            cnt_q <= cnt_q - DLY_W'(1);
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         el_q  <= '0;
         dly_q <= '0;
      end else if (trig_in && !busy_out) begin
         el_q  <= (DLY_W+1)'(1);
         dly_q <= bypass_in ? '0 : delay_in;
      end else if (el_q != '0) begin
         el_q <= el_q + (DLY_W+1)'(1);
      end
   end

   a_zero_delay_fire: assert property (
      @(posedge clk_in) disable iff (rst_in)
      trig_in && !busy_out && (delay_in == '0) |=> fire_out)
      else $error("Zero delay did not fire after one cycle");

   a_delay_exact: assert property (
      @(posedge clk_in) disable iff (rst_in)
      fire_out |-> (el_q == {1'b0, dly_q} + (DLY_W+1)'(1)))
      else $error("Delayed trigger fired at the wrong cycle");

   a_sync_bypass: assert property (
      @(posedge clk_in) disable iff (rst_in)
      trig_in && !busy_out && bypass_in |=> fire_out && !busy_out)
      else $error("Delay applied while cards are synchronised");

endmodule : tad_trig_delay

/* src/tad_trigger_engine.sv */
// Trigger engine: software trigger, force, arm and disarm, trigger output, delay
`timescale 1ns/1ps
`include "tad_cfg.svh"
// Functional notes
// - Software bit in OR mask triggers at once, no physical trigger needed.
// - Software mode starts acquisition once the card is started and armed.
// - Start delay is setup time plus recording the pre-trigger samples.
// - Output select zero leaves the connector unused, driver disabled.
// - Output select one drives an active-high pulse per detected trigger.
// - Force command acts only while waiting for a trigger, else ignored.
// - Each force command taken while waiting yields exactly one trigger event and one segment.
// - After a forced trigger the programmed mode resumes waiting for triggers.
// - Arm command enables the engine; enabled sources are then recognised.
// - Disarm command disables the engine; only force still triggers.
// - Engine leaves reset disarmed until an arm command arrives.
// - Delay register adds up to 65535 sample clocks to every trigger.
// - Delay zero adds nothing beyond the fixed internal latency.
// - Delay is the last stage, applied to the combined trigger.
// - A read-only register reports the largest supported delay.
// - Delay shifts the trigger only; pre and post counts stay unchanged.
// - With synchronised cards the delay setting is ignored.
module tad_trigger_engine #(
   parameter int CNT_W = 16
) (
   input  wire logic          CLOCK_IN,
   input  wire logic          RESET_IN,
   input  wire logic          HSEL_IN,
   input  wire logic [31:0]   HADDR_IN,
   input  wire logic [1:0]    HTRANS_IN,
   input  wire logic          HWRITE_IN,
   input  wire logic [2:0]    HSIZE_IN,
   input  wire logic          HREADY_IN,
   input  wire logic [31:0]   HWDATA_IN,
   output logic               HREADYOUT_OUT,
   output logic               HRESP_OUT,
   output logic [31:0]        HRDATA_OUT,
   input  wire logic          EXT_TRIG_IN,
   output logic               TRIG_OUT_OUT,
   output logic               TRIG_OE_OUT,
   output logic               ARMED_OUT,
   output logic               ACQ_ACTIVE_OUT
);
   import tad_pkg::*;

   localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(`TAD_SETUP_CYC);

   tad_idx_t         rd_idx;
   tad_idx_t         wr_idx;
   logic [31:0]      rd_data;
   logic [31:0]      wr_data;
   logic             wr_en;
   logic             wr_cmd;
   logic             cmd_start;
   logic             cmd_stop;
   logic             cmd_arm;
   logic             cmd_disarm;
   logic             cmd_force;
   logic             ext_s1_q;
   logic             ext_s2_q;
   logic             ext_s3_q;
   logic             ext_rise;
   logic             trig_event;
   logic             fire;
   logic             dly_busy;
   logic             armed_q;
   logic             sync_q;
   logic [31:0]      ormask_q;
   logic [31:0]      outsel_q;
   logic [CNT_W-1:0] delay_q;
   logic [CNT_W-1:0] pretrig_q;
   logic [CNT_W-1:0] posttrig_q;
   logic [CNT_W-1:0] cnt_q;
   tad_state_t       state_q;

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   tad_ahb_slave u_bus (
      .clk_in        (CLOCK_IN),
      .rst_in        (RESET_IN),
      .hsel_in       (HSEL_IN),
      .haddr_in      (HADDR_IN),
      .htrans_in     (HTRANS_IN),
      .hwrite_in     (HWRITE_IN),
      .hsize_in      (HSIZE_IN),
      .hready_in     (HREADY_IN),
      .hwdata_in     (HWDATA_IN),
      .hreadyout_out (HREADYOUT_OUT),
      .hresp_out     (HRESP_OUT),
      .hrdata_out    (HRDATA_OUT),
      .rd_idx_out    (rd_idx),
      .rd_data_in    (rd_data),
      .wr_en_out     (wr_en),
      .wr_idx_out    (wr_idx),
      .wr_data_out   (wr_data)
   );

   function automatic logic [31:0] read_mux(input tad_idx_t idx);
      case (idx)
         `TAD_IDX_OUTSEL:   read_mux = outsel_q;
         `TAD_IDX_ORMASK:   read_mux = ormask_q;
         `TAD_IDX_MAXDLY:   read_mux = `TAD_MAX_DELAY;
         `TAD_IDX_DELAY:    read_mux = 32'(delay_q);
         `TAD_IDX_CTRL:     read_mux = 32'(sync_q);
         `TAD_IDX_PRETRIG:  read_mux = 32'(pretrig_q);
         `TAD_IDX_POSTTRIG: read_mux = 32'(posttrig_q);
         `TAD_IDX_STATUS:   read_mux = {27'h0, dly_busy, armed_q, state_q};
         default:           read_mux = 32'h0000_0000;
      endcase
   endfunction : read_mux

   assign rd_data    = read_mux(rd_idx);
   assign wr_cmd     = wr_en && (wr_idx == `TAD_IDX_CMD);
   assign cmd_start  = wr_cmd && wr_data[`TAD_CMD_START];
   assign cmd_stop   = wr_cmd && wr_data[`TAD_CMD_STOP];
   assign cmd_arm    = wr_cmd && wr_data[`TAD_CMD_ARM];
   assign cmd_disarm = wr_cmd && wr_data[`TAD_CMD_DISARM];
   assign cmd_force  = wr_cmd && wr_data[`TAD_CMD_FORCE];

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   // Pre and post counts stay as written; the delay never touches them
   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         ormask_q   <= `TAD_RST_ORMASK;
         outsel_q   <= `TAD_RST_OUTSEL;
         delay_q    <= `TAD_RST_DELAY;
         sync_q     <= 1'b0;
         pretrig_q  <= `TAD_RST_PRETRIG;
         posttrig_q <= `TAD_RST_POSTTRIG;
      end else if (wr_en) begin
         case (wr_idx)
            `TAD_IDX_ORMASK:   ormask_q   <= wr_data;
            `TAD_IDX_OUTSEL:   outsel_q   <= wr_data;
            `TAD_IDX_DELAY:    delay_q    <= wr_data[CNT_W-1:0];
            `TAD_IDX_CTRL:     sync_q     <= wr_data[`TAD_CTRL_SYNC];
            `TAD_IDX_PRETRIG:  pretrig_q  <= wr_data[CNT_W-1:0];
            `TAD_IDX_POSTTRIG: posttrig_q <= wr_data[CNT_W-1:0];
            default:           ormask_q   <= ormask_q;
         endcase
      end
   end

   // Disarm wins when both bits arrive in one write
   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         armed_q <= 1'b0;
      end else if (cmd_disarm) begin
         armed_q <= 1'b0;
      end else if (cmd_arm) begin
         armed_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // External trigger pin
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= EXT_TRIG_IN;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_rise = ext_s2_q && !ext_s3_q;

   // ---------------------------------------------------------------
   // Trigger combination
   // ---------------------------------------------------------------
   // Force is a single write pulse, so it can only ever make one event
   assign trig_event = (state_q == ST_WAIT) && !cmd_stop &&
                       (cmd_force ||
                        (armed_q && (ormask_q[`TAD_OR_SOFT] ||
                                     (ormask_q[`TAD_OR_EXT] && ext_rise))));

   // Forced and normal events share one delay stage
   tad_trig_delay #(
      .DLY_W (CNT_W)
   ) u_delay (
      .clk_in    (CLOCK_IN),
      .rst_in    (RESET_IN),
      .trig_in   (trig_event),
      .delay_in  (delay_q),
      .bypass_in (sync_q),
      .fire_out  (fire),
      .busy_out  (dly_busy)
   );

   // ---------------------------------------------------------------
   // Acquisition sequence
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         state_q <= ST_STOPPED;
         cnt_q   <= '0;
      end else if (cmd_stop) begin
         state_q <= ST_STOPPED;
      end else begin
         case (state_q)
            ST_STOPPED: begin
               if (cmd_start) begin
                  state_q <= ST_SETUP;
                  cnt_q   <= SETUP_CYC - CNT_W'(1);
               end
            end
            ST_SETUP: begin
               if (cnt_q == '0) begin
                  state_q <= ST_PRETRIG;
                  cnt_q   <= pretrig_q;
               end else begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end
            end
            ST_PRETRIG: begin
               if (cnt_q == '0) begin
                  state_q <= ST_WAIT;
               end else begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end
            end
            ST_WAIT: begin
               if (trig_event) begin
                  state_q <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (fire) begin
                  state_q <= ST_POST;
                  cnt_q   <= posttrig_q;
               end
            end
            ST_POST: begin
               if (cnt_q == '0) begin
                  state_q <= ST_WAIT;
               end else begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end
            end
            default: state_q <= ST_STOPPED;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Output pins
   // ---------------------------------------------------------------
   // Driver stays off unless select is exactly one
   always_ff @(posedge CLOCK_IN) begin
      if (RESET_IN) begin
         TRIG_OE_OUT    <= 1'b0;
         TRIG_OUT_OUT   <= 1'b0;
         ARMED_OUT      <= 1'b0;
         ACQ_ACTIVE_OUT <= 1'b0;
      end else begin
         TRIG_OE_OUT    <= (outsel_q == `TAD_OUTSEL_DRIVE);
         TRIG_OUT_OUT   <= (outsel_q == `TAD_OUTSEL_DRIVE) && fire;
         ARMED_OUT      <= armed_q;
         ACQ_ACTIVE_OUT <= (state_q != ST_STOPPED);
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_enter_setup;
      (state_q == ST_STOPPED) && cmd_start && !cmd_stop;
   endsequence

   sequence s_setup_run;
      (state_q == ST_SETUP)[*4] ##1 (state_q == ST_PRETRIG);
   endsequence

   a_setup_time: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      s_enter_setup |=> s_setup_run)
      else $error("Setup phase length wrong");

   a_reset_disarm: assert property (
      @(posedge CLOCK_IN)
      RESET_IN |=> !armed_q)
      else $error("Engine armed after reset");

   a_arm_cmd: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      cmd_arm && !cmd_disarm |=> armed_q ##1 ARMED_OUT)
      else $error("Arm command did not arm");

   a_disarm_block: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      (state_q == ST_WAIT) && !armed_q && !cmd_force |=> state_q != ST_DELAY)
      else $error("Disarmed engine accepted a trigger");

   a_force_taken: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      (state_q == ST_WAIT) && cmd_force && !cmd_stop |=> state_q == ST_DELAY)
      else $error("Force ignored while waiting");

   a_force_ignored: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      cmd_force && (state_q != ST_WAIT) |-> !trig_event)
      else $error("Force acted outside the waiting state");

   a_soft_start: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      (state_q == ST_WAIT) && armed_q && ormask_q[`TAD_OR_SOFT] && !cmd_stop
      |=> state_q == ST_DELAY)
      else $error("Software trigger did not start at once");

   a_oe_off: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      (outsel_q != `TAD_OUTSEL_DRIVE) |=> !TRIG_OE_OUT && !TRIG_OUT_OUT)
      else $error("Trigger driver enabled with select off");

   a_out_pulse: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      fire && (outsel_q == `TAD_OUTSEL_DRIVE) |=> TRIG_OUT_OUT && TRIG_OE_OUT)
      else $error("Detected trigger not shown on output");

   a_post_count: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      (state_q == ST_DELAY) && fire && !cmd_stop |=> cnt_q == posttrig_q)
      else $error("Post-trigger count altered by delay");

   a_pretrig_load: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      (state_q == ST_SETUP) && (cnt_q == '0) && !cmd_stop
      |=> (state_q == ST_PRETRIG) && (cnt_q == $past(pretrig_q)))
      else $error("Pre-trigger count not loaded after setup");

   a_ext_accept: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      (state_q == ST_WAIT) && armed_q && ormask_q[`TAD_OR_EXT] && ext_rise && !cmd_stop
      |=> state_q == ST_DELAY)
      else $error("Armed engine missed an external trigger");

   a_post_resume: assert property (
      @(posedge CLOCK_IN) disable iff (RESET_IN)
      (state_q == ST_POST) && (cnt_q == '0) && !cmd_stop |=> state_q == ST_WAIT)
      else $error("Engine did not resume waiting after a segment");

endmodule : tad_trigger_engine

/* verification/tad_ext_equip.sv */
// Model of external equipment: counts trigger pulses, drives the external trigger pin
`timescale 1ns/1ps
module tad_ext_equip (
   input  wire logic clk_in,
   input  wire logic trig_in,
   input  wire logic oe_in,
   input  wire logic fire_in,
   output logic      ext_out,
   output int        count_out
);
   // ---------------------------------------------------------------
   // Pulse counter
   // ---------------------------------------------------------------
   initial count_out = 0;
   initial ext_out = 1'b0;
   // Pulse without the driver enabled never reaches the cable
   always @(posedge clk_in) if (trig_in && oe_in) count_out <= count_out + 1;
   // Edge source, changed only after a clock edge
   always @(posedge clk_in) ext_out <= fire_in;
endmodule : tad_ext_equip

/* verification/tad_trigger_engine_tb.sv */
// Self-checking bench of the trigger engine: registers, trigger timing, force and arm
`timescale 1ns/1ps
`include "tad_cfg.svh"
module tad_trigger_engine_tb;
   import tad_pkg::*;
   localparam logic [31:0] c_start = 32'h0000_0004;
   localparam logic [31:0] c_arm   = 32'h0000_0008;
   localparam logic [31:0] c_force = 32'h0000_0010;
   localparam logic [31:0] c_dis   = 32'h0000_0020;
   logic        clk, rst, hsel, hwrite, fire, hready, hresp, trig, oe, armed, acq, ext;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   int          miscompares = 0, cmp_count = 0, cyc = 0, cnt, n0, n1, c;

   tad_trigger_engine u_tad_trigger_engine (.CLOCK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel),
      .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
      .HREADY_IN(hready), .HWDATA_IN(hwdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .HRDATA_OUT(hrdata), .EXT_TRIG_IN(ext), .TRIG_OUT_OUT(trig), .TRIG_OE_OUT(oe),
      .ARMED_OUT(armed), .ACQ_ACTIVE_OUT(acq));
   tad_ext_equip u_tad_ext_equip (.clk_in(clk), .trig_in(trig), .oe_in(oe), .fire_in(fire),
      .ext_out(ext), .count_out(cnt));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Whole run needs about 475 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
      htrans <= `TAD_HTRANS_NONSEQ;
      haddr  <= {14'h0000, i, 2'b00};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask : bus
   task automatic wr(input logic [15:0] i, input logic [31:0] d);
      bus(1'b1, i, d);
   endtask : wr
   task automatic rc(input string nm, input logic [15:0] i, input logic [31:0] e);
      bus(1'b0, i, 32'h0000_0000);
      chk(nm, e, rdv);
      chk("hresp", 32'h0000_0000, {31'h0, hresp});
   endtask : rc
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle
   // Cycles until the output pulse, sampled mid-cycle where it is settled
   task automatic lat(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (trig !== 1'b1 && n < 300);
      chk("pulse", 32'h0000_0001, {31'h0, trig});
      @(posedge clk);
   endtask : lat
   task automatic rearm(input logic [31:0] d, output int n);
      wr(`TAD_IDX_CMD, c_dis);
      idle(40);
      wr(`TAD_IDX_DELAY, d);
      wr(`TAD_IDX_CMD, c_arm);
      lat(n);
   endtask : rearm
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1; hsel = 1'b1; hwrite = 1'b0; htrans = 2'h0; hsize = `TAD_HSIZE_WORD;
      haddr = 32'h0000_0000; hwdata = 32'h0000_0000; fire = 1'b0;
      idle(4);
      rst <= 1'b0;
      @(posedge clk);
      chk("armed", 32'h0000_0000, {31'h0, armed});
      chk("oe", 32'h0000_0000, {31'h0, oe});
      rc("status", `TAD_IDX_STATUS, 32'h0000_0000);
      rc("maxdly", `TAD_IDX_MAXDLY, `TAD_MAX_DELAY);
      rc("ormask", `TAD_IDX_ORMASK, `TAD_RST_ORMASK);
      rc("unmapped", 16'h0001, 32'h0000_0000);
      rc("cmd", `TAD_IDX_CMD, 32'h0000_0000);
      wr(`TAD_IDX_DELAY, 32'h0000_FFFF);
      rc("delay", `TAD_IDX_DELAY, 32'h0000_FFFF);
      hsize <= 3'h0;
      wr(`TAD_IDX_DELAY, 32'h0000_1234);
      hsize <= `TAD_HSIZE_WORD;
      rc("narrow", `TAD_IDX_DELAY, 32'h0000_FFFF);
      wr(`TAD_IDX_DELAY, 32'h0000_0000);
      wr(`TAD_IDX_PRETRIG, 32'h0000_0002);
      wr(`TAD_IDX_POSTTRIG, 32'h0000_0003);
      wr(`TAD_IDX_OUTSEL, `TAD_OUTSEL_DRIVE);
      idle(2);
      chk("oe", 32'h0000_0001, {31'h0, oe});
      wr(`TAD_IDX_CMD, c_start);
      idle(20);
      chk("acq", 32'h0000_0001, {31'h0, acq});
      rc("waiting", `TAD_IDX_STATUS, 32'h0000_0003);
      chk("no pulse", 32'h0000_0000, cnt);
      wr(`TAD_IDX_CMD, c_arm);
      lat(n0);
      chk("latency", 32'h0000_0003, n0);
      rearm(32'h0000_0005, n1);
      chk("delay", 32'h0000_0005, n1 - n0);
      wr(`TAD_IDX_CTRL, 32'h0000_0001);
      rearm(32'h0000_0005, n1);
      chk("sync", n0, n1);
      wr(`TAD_IDX_CTRL, 32'h0000_0000);
      wr(`TAD_IDX_CMD, c_dis);
      idle(40);
      wr(`TAD_IDX_ORMASK, 32'h0000_0000);
      c = cnt;
      wr(`TAD_IDX_CMD, c_force);
      idle(30);
      chk("force", c + 1, cnt);
      rc("resume", `TAD_IDX_STATUS, 32'h0000_0003);
      wr(`TAD_IDX_CMD, c_arm);
      idle(30);
      chk("masked", c + 1, cnt);
      chk("armed out", 32'h0000_0001, {31'h0, armed});
      rc("armed", `TAD_IDX_STATUS, 32'h0000_000B);
      wr(`TAD_IDX_ORMASK, 32'h0000_0002);
      fire <= 1'b1;
      idle(3);
      fire <= 1'b0;
      idle(30);
      chk("ext", c + 2, cnt);
      wr(`TAD_IDX_CMD, 32'h0000_0060);
      idle(30);
      chk("acq stop", 32'h0000_0000, {31'h0, acq});
      wr(`TAD_IDX_CMD, c_force);
      idle(30);
      chk("force stopped", c + 2, cnt);
      wr(`TAD_IDX_ORMASK, 32'h0000_0001);
      wr(`TAD_IDX_CMD, c_arm);
      wr(`TAD_IDX_CMD, c_start);
      lat(n0);
      chk("start time", `TAD_SETUP_CYC + 11, n0);
      wr(`TAD_IDX_CMD, 32'h0000_0060);
      idle(40);
      wr(`TAD_IDX_PRETRIG, 32'h0000_0006);
      wr(`TAD_IDX_CMD, c_arm);
      wr(`TAD_IDX_CMD, c_start);
      lat(n1);
      chk("pretrig time", 32'h0000_0004, n1 - n0);
      rc("pretrig", `TAD_IDX_PRETRIG, 32'h0000_0006);
      report_and_stop();
   end
endmodule : tad_trigger_engine_tb
